// ### core/queue_manager.sv
// Function
// RULE1: Underrun plays substitute data for whole frames.
// RULE2: Substitute is last timeslot value or fixed byte.
// RULE3: Late packet is played normally on arrival.
// RULE4: No loss detection; next packet plays immediately.
// RULE5: Late packets grow depth; depth never shrinks automatically.
// RULE6: At drop threshold, arrivals are discarded.
// RULE7: Backplane threshold 0 to 15, step one.
// RULE8: Network threshold 15 to 255, step sixteen.
// RULE9: One control bit selects threshold range.
// RULE10: First packet held off programmed frame periods.
// RULE11: Separate limited queue for every context.
// RULE12: Four class queues per port, any assignment.
// RULE13: Option maps classes to strict or fair.
// RULE14: Strict queues served before fair queues.
// RULE15: Higher strict class always served first.
// RULE16: Scheduling is non-preemptive between packets.
// RULE17: Software keeps fair weights 1..64, totalling 64.
// RULE18: Four host queues filled by traffic class.
// RULE19: Underruns and threshold drops raise status events.
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module queue_manager
   import qm_pkg::*;
#(
   parameter int NCTX = 128,
   parameter int NPORT = 2,
   parameter int NTS = 32,
   parameter int FRAME_CYCLES = FRAME_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // Classifier arrivals
   input wire logic arr_valid_i,
   input wire logic [1:0] arr_dest_i,
   input wire logic [$clog2(NCTX)-1:0] arr_ctx_i,
   input wire logic [$clog2(NPORT)-1:0] arr_port_i,
   input wire logic [1:0] arr_class_i,
   output logic arr_accept_o,
   output logic arr_drop_o,
   // TDM formatter play-out
   input wire logic play_req_i,
   input wire logic [$clog2(NCTX)-1:0] play_ctx_i,
   output logic play_take_o,
   output logic play_fill_o,
   output logic frame_tick_o,
   input wire logic slot_valid_i,
   input wire logic [$clog2(NCTX)-1:0] slot_ctx_i,
   input wire logic [$clog2(NTS)-1:0] slot_ts_i,
   input wire logic [7:0] slot_byte_i,
   output logic tdm_valid_o,
   output logic [7:0] tdm_byte_o,
   // Ethernet MAC ports
   input wire logic [NPORT-1:0] mac_ready_i,
   input wire logic [NPORT-1:0] tx_done_i,
   output logic [NPORT-1:0] tx_grant_o,
   output logic [2*NPORT-1:0] tx_class_o,
   // Host queues
   input wire logic [3:0] host_pop_i,
   output logic [3:0] host_nonempty_o
);

   localparam int CW = $clog2(NCTX);
   localparam int FW = $clog2(FRAME_CYCLES);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic net_mode_q;
   logic repeat_q;
   logic [1:0] option_q;
   logic [7:0] fill_q;
   logic [7:0] hold_cfg_q;
   logic [3:0] stat_q;
   logic [3:0] mask_q;
   logic [CW-1:0] sel_q;
   logic [27:0] weights_q;
   logic [FW-1:0] div_q;
   logic [3:0] thr_q [NCTX];
   logic en_q [NCTX];
   logic started_q [NCTX];
   logic under_q [NCTX];
   logic [7:0] hold_q [NCTX];
   logic [7:0] depth_q [NCTX];
   logic [7:0] last_q [NTS];
   logic [7:0] portq_q [4*NPORT];
   logic [7:0] hostq_q [4];

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wire bus_req = wb_cyc_i && wb_stb_i;
   wire bus_wr = bus_req && wb_we_i && wb_ack_o;
   wire wr_ctrl = bus_wr && (wb_adr_i == CTRL_OFS);
   wire wr_stat = bus_wr && (wb_adr_i == STAT_OFS) && wb_sel_i[0];
   wire wr_mask = bus_wr && (wb_adr_i == MASK_OFS) && wb_sel_i[0];
   wire wr_sel = bus_wr && (wb_adr_i == CTX_SEL_OFS) && wb_sel_i[0];
   wire wr_cfg = bus_wr && (wb_adr_i == CTX_CFG_OFS) && wb_sel_i[1];
   wire wr_wgt = bus_wr && (wb_adr_i == WEIGHT_OFS);
   logic [31:0] rd_data;

   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         CTRL_OFS: begin
            rd_data[CTRL_NET_BIT] = net_mode_q;
            rd_data[CTRL_REPEAT_BIT] = repeat_q;
            rd_data[CTRL_OPT_LSB +: 2] = option_q;
            rd_data[CTRL_FILL_LSB +: 8] = fill_q;
            rd_data[CTRL_HOLD_LSB +: 8] = hold_cfg_q;
         end
         STAT_OFS: rd_data[3:0] = stat_q;
         MASK_OFS: rd_data[3:0] = mask_q;
         CTX_SEL_OFS: rd_data[CW-1:0] = sel_q;
         CTX_CFG_OFS: begin
            rd_data[3:0] = thr_q[sel_q];
            rd_data[CFG_EN_BIT] = en_q[sel_q];
            rd_data[CFG_DEPTH_LSB +: 8] = depth_q[sel_q];
         end
         WEIGHT_OFS: rd_data = {1'b0, weights_q[27:21], 1'b0, weights_q[20:14],
                                1'b0, weights_q[13:7], 1'b0, weights_q[6:0]};
         HOSTQ_OFS: rd_data = {hostq_q[3], hostq_q[2], hostq_q[1], hostq_q[0]};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------------
   // Arrival admission
   // ----------------------------------------------------------------------
   wire [7:0] thr_code = {4'h0, thr_q[arr_ctx_i]};
   // Network range: code 0..15 maps to 15, 31, .. 255 packets.
   wire [7:0] ctx_limit = net_mode_q ? ((thr_code << NET_STEP_SHIFT) | NET_STEP_OFS) // [RULE8] [RULE9]
                                     : thr_code; // [RULE7]
   wire arr_ctx = arr_valid_i && (arr_dest_i == DEST_CTX);
   wire arr_port = arr_valid_i && (arr_dest_i == DEST_PORT);
   wire arr_host = arr_valid_i && (arr_dest_i == DEST_HOST);
   wire [$clog2(4*NPORT)-1:0] pq_idx = {arr_port_i, arr_class_i};
   wire ctx_drop = arr_ctx && (!en_q[arr_ctx_i] || depth_q[arr_ctx_i] >= ctx_limit); // [RULE6] [RULE11]
   wire port_drop = arr_port && (portq_q[pq_idx] == QUEUE_FULL);
   wire host_drop = arr_host && (hostq_q[arr_class_i] == QUEUE_FULL);
   wire any_drop = ctx_drop || port_drop || host_drop || (arr_valid_i && arr_dest_i == DEST_NONE);

   // ----------------------------------------------------------------------
   // Play-out decision
   // ----------------------------------------------------------------------
   wire frame_tick = (div_q == FW'(FRAME_CYCLES - 1));
   wire play_ready = started_q[play_ctx_i] && (hold_q[play_ctx_i] == 8'h00);
   // Whatever is queued is taken at once; there is no sequence to wait on.
   wire play_take = play_req_i && play_ready && (depth_q[play_ctx_i] != 8'h00); // [RULE3] [RULE4]
   wire play_under = play_req_i && play_ready && (depth_q[play_ctx_i] == 8'h00); // [RULE1]
   wire slot_fill = !started_q[slot_ctx_i] || (hold_q[slot_ctx_i] != 8'h00) || under_q[slot_ctx_i];
   wire [7:0] fill_byte = repeat_q ? last_q[slot_ts_i] : fill_q; // [RULE2]
   wire [7:0] slot_out = slot_fill ? fill_byte : slot_byte_i;

   // ----------------------------------------------------------------------
   // Events
   // ----------------------------------------------------------------------
   wire [3:0] ev_set = {host_drop, port_drop, ctx_drop, play_under}; // [RULE19]
   wire [3:0] ev_clr = wr_stat ? wb_dat_i[3:0] : 4'h0;
   // A new event in the clearing cycle survives the write.
   wire [3:0] stat_d = (stat_q & ~ev_clr) | ev_set;

   // ----------------------------------------------------------------------
   // Control and bus registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         net_mode_q <= 1'b0;
         repeat_q <= 1'b0;
         option_q <= OPT_RST;
         fill_q <= FILL_RST;
         hold_cfg_q <= HOLD_RST;
         stat_q <= 4'h0;
         mask_q <= 4'h0;
         irq_o <= 1'b0;
         sel_q <= '0;
         weights_q <= {4{WEIGHT_RST}};
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
         wb_dat_o <= rd_data;
         if (wr_ctrl && wb_sel_i[0]) begin
            net_mode_q <= wb_dat_i[CTRL_NET_BIT];
            repeat_q <= wb_dat_i[CTRL_REPEAT_BIT];
            option_q <= wb_dat_i[CTRL_OPT_LSB +: 2];
         end
         if (wr_ctrl && wb_sel_i[1]) fill_q <= wb_dat_i[CTRL_FILL_LSB +: 8];
         if (wr_ctrl && wb_sel_i[2]) hold_cfg_q <= wb_dat_i[CTRL_HOLD_LSB +: 8];
         stat_q <= stat_d;
         if (wr_mask) mask_q <= wb_dat_i[3:0];
         irq_o <= |(stat_d & mask_q);
         if (wr_sel) sel_q <= wb_dat_i[CW-1:0];
         // Weights are taken as written; keeping them legal is software's job.
         for (int b = 0; b < 4; b++) begin
            if (wr_wgt && wb_sel_i[b]) weights_q[b*7 +: 7] <= wb_dat_i[b*8 +: 7]; // [RULE17]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Frame divider and TDM byte path
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= '0;
         frame_tick_o <= 1'b0;
         tdm_valid_o <= 1'b0;
         tdm_byte_o <= 8'h00;
         for (int t = 0; t < NTS; t++) begin
            last_q[t] <= 8'h00;
         end
      end else begin
         div_q <= frame_tick ? '0 : div_q + FW'(1);
         frame_tick_o <= frame_tick;
         tdm_valid_o <= slot_valid_i;
         if (slot_valid_i) begin
            tdm_byte_o <= slot_out;
            last_q[slot_ts_i] <= slot_out;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Context queues
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arr_accept_o <= 1'b0;
         arr_drop_o <= 1'b0;
         play_take_o <= 1'b0;
         play_fill_o <= 1'b0;
         for (int c = 0; c < NCTX; c++) begin
            thr_q[c] <= 4'h0;
            en_q[c] <= 1'b0;
            started_q[c] <= 1'b0;
            under_q[c] <= 1'b0;
            hold_q[c] <= 8'h00;
            depth_q[c] <= 8'h00;
         end
      end else begin
         arr_accept_o <= arr_valid_i && !any_drop;
         arr_drop_o <= arr_valid_i && any_drop;
         play_take_o <= play_take;
         play_fill_o <= play_req_i && !play_take;
         for (int c = 0; c < NCTX; c++) begin
            if (frame_tick && hold_q[c] != 8'h00) hold_q[c] <= hold_q[c] - 8'h01; // [RULE10]
         end
         if (arr_ctx && !ctx_drop && !started_q[arr_ctx_i]) begin
            started_q[arr_ctx_i] <= 1'b1;
            hold_q[arr_ctx_i] <= hold_cfg_q; // [RULE10]
         end
         // The late packet stays queued behind the frames already filled, so
         // the depth gained by lateness is kept.
         if (play_under) under_q[play_ctx_i] <= 1'b1; // [RULE1] [RULE5]
         if (play_take) under_q[play_ctx_i] <= 1'b0; // [RULE3]
         if (arr_ctx && !ctx_drop && !(play_take && play_ctx_i == arr_ctx_i)) begin
            depth_q[arr_ctx_i] <= depth_q[arr_ctx_i] + 8'h01; // [RULE11]
         end else if (play_take && !(arr_ctx && !ctx_drop && play_ctx_i == arr_ctx_i)) begin
            depth_q[play_ctx_i] <= depth_q[play_ctx_i] - 8'h01; // [RULE6]
         end
         if (wr_cfg || (wr_cfg && wb_sel_i[0])) begin
            en_q[sel_q] <= wb_dat_i[CFG_EN_BIT];
            if (!wb_dat_i[CFG_EN_BIT]) begin
               started_q[sel_q] <= 1'b0;
               under_q[sel_q] <= 1'b0;
               depth_q[sel_q] <= 8'h00;
            end
         end
         if (bus_wr && (wb_adr_i == CTX_CFG_OFS) && wb_sel_i[0]) thr_q[sel_q] <= wb_dat_i[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // Port and host queues
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         host_nonempty_o <= 4'h0;
         for (int q = 0; q < 4*NPORT; q++) begin
            portq_q[q] <= 8'h00;
         end
         for (int h = 0; h < 4; h++) begin
            hostq_q[h] <= 8'h00;
         end
      end else begin
         for (int q = 0; q < 4*NPORT; q++) begin
            if (arr_port && !port_drop && pq_idx == q[$clog2(4*NPORT)-1:0]) begin
               if (!(tx_grant_o[q/4] && tx_class_o[(q/4)*2 +: 2] == 2'(q)))
                  portq_q[q] <= portq_q[q] + 8'h01; // [RULE12]
            end else if (tx_grant_o[q/4] && tx_class_o[(q/4)*2 +: 2] == 2'(q) && portq_q[q] != 8'h00) begin
               portq_q[q] <= portq_q[q] - 8'h01;
            end
         end
         for (int h = 0; h < 4; h++) begin
            if (arr_host && !host_drop && arr_class_i == 2'(h)) begin
               if (!(host_pop_i[h] && hostq_q[h] != 8'h00))
                  hostq_q[h] <= hostq_q[h] + 8'h01; // [RULE18]
            end else if (host_pop_i[h] && hostq_q[h] != 8'h00) begin
               hostq_q[h] <= hostq_q[h] - 8'h01;
            end
            host_nonempty_o[h] <= (hostq_q[h] != 8'h00) || (arr_host && !host_drop && arr_class_i == 2'(h));
         end
      end
   end

   // ----------------------------------------------------------------------
   // Per-port schedulers
   // ----------------------------------------------------------------------
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      // The nonempty flags come straight from the queue counts; a queue granted
      // this cycle is not masked out.
      wire [3:0] nonempty = {portq_q[p*4+3] != 8'h00, portq_q[p*4+2] != 8'h00,
                             portq_q[p*4+1] != 8'h00, portq_q[p*4] != 8'h00};
      port_scheduler u_sched (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .nonempty_i(nonempty),
         .option_i(option_q),
         .weights_i(weights_q),
         .mac_ready_i(mac_ready_i[p]),
         .tx_done_i(tx_done_i[p]),
         .grant_o(tx_grant_o[p]),
         .class_o(tx_class_o[p*2 +: 2])
      ); // [RULE12] [RULE14] [RULE16]
   end

endmodule // queue_manager
`default_nettype wire

// ### inc/qm_pkg.sv
package qm_pkg;

   // ----------------------------------------------------------------------
   // Register offsets (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;
   localparam logic [7:0] CTX_SEL_OFS = 8'h0c;
   localparam logic [7:0] CTX_CFG_OFS = 8'h10;
   localparam logic [7:0] WEIGHT_OFS = 8'h14;
   localparam logic [7:0] HOSTQ_OFS = 8'h18;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int CTRL_NET_BIT = 0;
   localparam int CTRL_REPEAT_BIT = 1;
   localparam int CTRL_OPT_LSB = 4;
   localparam int CTRL_FILL_LSB = 8;
   localparam int CTRL_HOLD_LSB = 16;
   localparam int STAT_UNDERRUN_BIT = 0;
   localparam int STAT_CTX_DROP_BIT = 1;
   localparam int STAT_PORT_DROP_BIT = 2;
   localparam int STAT_HOST_DROP_BIT = 3;
   localparam int CFG_EN_BIT = 8;
   localparam int CFG_DEPTH_LSB = 16;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] FILL_RST = 8'hff;
   localparam logic [7:0] HOLD_RST = 8'h04;
   localparam logic [1:0] OPT_RST = 2'h0;
   localparam logic [6:0] WEIGHT_RST = 7'h10;

   // ----------------------------------------------------------------------
   // Thresholds, weights and timing
   // ----------------------------------------------------------------------
   localparam logic [7:0] NET_STEP_OFS = 8'h0f;
   localparam int NET_STEP_SHIFT = 4;
   localparam logic [7:0] QUEUE_FULL = 8'hff;
   localparam int FRAME_NS = 125000;
   localparam int CLK_NS = 25;
   localparam int FRAME_CYC = FRAME_NS / CLK_NS;

   // ----------------------------------------------------------------------
   // Arrival destinations and scheduler states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      DEST_CTX,
      DEST_PORT,
      DEST_HOST,
      DEST_NONE
   } dest_type;

   typedef enum {
      SCHED_IDLE,
      SCHED_BUSY
   } sched_state_type;

endpackage

// ### core/port_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
module port_scheduler
   import qm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] nonempty_i,
   input wire logic [1:0] option_i,
   input wire logic [27:0] weights_i,
   input wire logic mac_ready_i,
   input wire logic tx_done_i,
   output logic grant_o,
   output logic [1:0] class_o
);

   sched_state_type state_q;
   logic [6:0] credit_q [4];
   logic [3:0] strict_mask;
   logic [3:0] sp_req;
   logic [3:0] fq_req;
   logic [3:0] fq_credit;
   logic reload;
   logic [3:0] pick_set;
   logic [1:0] pick;
   logic start;

   // ----------------------------------------------------------------------
   // Class selection
   // ----------------------------------------------------------------------
   // Option 0 is the default: classes 3..1 strict, class 0 fair.
   assign strict_mask = (option_i == 2'h0) ? 4'he : (option_i == 2'h1) ? 4'hc :
                        (option_i == 2'h2) ? 4'h8 : 4'h0; // [RULE13]
   assign sp_req = nonempty_i & strict_mask;
   assign fq_req = nonempty_i & ~strict_mask;
   assign fq_credit = fq_req & {credit_q[3] != 7'h00, credit_q[2] != 7'h00,
                                credit_q[1] != 7'h00, credit_q[0] != 7'h00};
   // A round ends when no waiting fair class has credit left; only the waiting fair classes are refilled.
   assign reload = (sp_req == 4'h0) && (fq_credit == 4'h0);
   assign pick_set = (sp_req != 4'h0) ? sp_req : reload ? fq_req : fq_credit; // [RULE14]
   assign pick = pick_set[3] ? 2'h3 : pick_set[2] ? 2'h2 : pick_set[1] ? 2'h1 : 2'h0; // [RULE15]
   // Only an idle scheduler decides, so a running packet is never cut short.
   assign start = (state_q == SCHED_IDLE) && mac_ready_i && (nonempty_i != 4'h0); // [RULE16]

   // ----------------------------------------------------------------------
   // State and credits
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      grant_o <= 1'b0;
      if (rst_i) begin
         state_q <= SCHED_IDLE;
         class_o <= 2'h0;
         for (int c = 0; c < 4; c++) begin
            credit_q[c] <= WEIGHT_RST;
         end
      end else begin
         case (state_q)
            SCHED_IDLE: begin
               if (start) begin
                  grant_o <= 1'b1;
                  class_o <= pick;
                  state_q <= SCHED_BUSY;
                  for (int c = 0; c < 4; c++) begin
                     if (reload && fq_req[c]) begin
                        credit_q[c] <= weights_i[c*7 +: 7] - ((pick == 2'(c)) ? 7'h01 : 7'h00);
                     end else if (sp_req == 4'h0 && pick == 2'(c) && credit_q[c] != 7'h00) begin
                        credit_q[c] <= credit_q[c] - 7'h01;
                     end
                  end
               end
            end
            SCHED_BUSY: begin
               if (tx_done_i) begin
                  state_q <= SCHED_IDLE;
               end
            end
            default: state_q <= SCHED_IDLE;
         endcase
      end
   end

endmodule // port_scheduler
`default_nettype wire

// ### verification/qm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module qm_properties #(parameter int NPORT = 2) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic arr_valid_i,
   input wire logic arr_accept_o,
   input wire logic arr_drop_o,
   input wire logic play_req_i,
   input wire logic play_take_o,
   input wire logic play_fill_o,
   input wire logic frame_tick_o,
   input wire logic [NPORT-1:0] mac_ready_i,
   input wire logic [NPORT-1:0] tx_done_i,
   input wire logic [NPORT-1:0] tx_grant_o,
   input wire logic [2*NPORT-1:0] tx_class_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Port 0 is busy from its grant until the MAC reports the end of the packet.
   logic busy_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || tx_done_i[0]) busy_q <= 1'b0;
      else if (tx_grant_o[0]) busy_q <= 1'b1;
   end
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   property p_ack; s_req |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_arr; arr_valid_i |=> arr_accept_o ^ arr_drop_o; endproperty
   a_arr: assert property (p_arr) else $error("arrival unanswered");
   property p_play; play_req_i |=> play_take_o ^ play_fill_o; endproperty
   a_play: assert property (p_play) else $error("play unanswered");
   property p_grant; tx_grant_o[0] |-> $past(mac_ready_i[0]); endproperty
   a_grant: assert property (p_grant) else $error("grant without ready");
   property p_nopre; busy_q && !tx_done_i[0] |=> !tx_grant_o[0]; endproperty
   a_nopre: assert property (p_nopre) else $error("grant while busy");
   property p_class; !tx_grant_o[0] |-> $stable(tx_class_o[1:0]); endproperty
   a_class: assert property (p_class) else $error("class moved");
   property p_frame; frame_tick_o |=> (!frame_tick_o)[*8]; endproperty
   a_frame: assert property (p_frame) else $error("tick too soon");
endmodule // qm_properties
`default_nettype wire

// ### verification/mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic slow_i,
   input wire logic [1:0] grant_i,
   output logic [1:0] ready_o,
   output logic [1:0] done_o
);
   logic [3:0] cnt_q [2];
   always_ff @(posedge clk_i) begin
      for (int p = 0; p < 2; p++) begin
         if (rst_i) cnt_q[p] <= 4'h0;
         else if (grant_i[p]) cnt_q[p] <= slow_i ? 4'hc : 4'h3;
         else if (cnt_q[p] != 4'h0) cnt_q[p] <= cnt_q[p] - 4'h1;
      end
   end
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         done_o[p] = cnt_q[p] == 4'h1;
         ready_o[p] = en_i && cnt_q[p] == 4'h0 && !grant_i[p];
      end
   end
endmodule // mac_model
`default_nettype wire

// ### verification/queue_manager_tb.sv
`timescale 1ns/1ps
`default_nettype none
module queue_manager_tb;
   import qm_pkg::*;
   localparam int FR = 20;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, slot_byte_i = 8'h00, tdm_byte_o;
   logic [3:0] wb_sel_i = 4'h0, host_pop_i = 4'h0, tx_class_o, host_nonempty_o;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, irq_o, arr_accept_o, arr_drop_o, play_take_o, play_fill_o, frame_tick_o, tdm_valid_o;
   logic arr_valid_i = 1'b0, play_req_i = 1'b0, slot_valid_i = 1'b0, mac_en = 1'b0, mac_slow = 1'b0;
   logic [1:0] arr_dest_i = 2'h0, arr_class_i = 2'h0, mac_ready_i, tx_done_i, tx_grant_o;
   logic [6:0] arr_ctx_i = 7'h00, play_ctx_i = 7'h00, slot_ctx_i = 7'h00;
   logic [0:0] arr_port_i = 1'b0;
   logic [4:0] slot_ts_i = 5'h00;
   int n_fail = 0, cmp_count = 0, cyc_n = 0;
   integer seed = 32'h6611;
   logic [11:0] ev_q[$];
   logic [31:0] rd_q[$];
   queue_manager #(.FRAME_CYCLES(FR)) DUT (.*);
   mac_model u_mac (.clk_i(clk_i), .rst_i(rst_i), .en_i(mac_en), .slow_i(mac_slow),
      .grant_i(tx_grant_o), .ready_o(mac_ready_i), .done_o(tx_done_i));
   initial forever #12.5 clk_i = ~clk_i;
   // ----------------------------------------------------------------------
   // Comparison and bus tasks
   // ----------------------------------------------------------------------
   task cmp_ev(input logic [11:0] e, input logic [11:0] got);
      cmp_count++;
      if (got !== e) begin
         n_fail++;
         $display("ERROR event exp %h got %h", e, got);
      end
   endtask
   task cmp_rd(input logic [31:0] got);
      logic [31:0] e;
      e = rd_q.size() ? rd_q.pop_front() : 32'hdead;
      cmp_count++;
      if (got !== e) begin
         n_fail++;
         $display("ERROR read exp %h got %h", e, got);
      end
   endtask
   task stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 20);
      if (t == 20) n_fail++;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task arr(input logic [1:0] d, input logic [6:0] c, input logic [1:0] k, input logic [3:0] e);
      @(posedge clk_i);
      {arr_valid_i, arr_dest_i, arr_ctx_i, arr_class_i} <= {1'b1, d, c, k};
      ev_q.push_back({8'h10, e});
      @(posedge clk_i);
      arr_valid_i <= 1'b0;
   endtask
   // One play request every FR+1 cycles, one cycle longer than a frame.
   task play(input logic [3:0] e);
      repeat (FR) @(posedge clk_i);
      {play_req_i, play_ctx_i} <= {1'b1, 7'h05};
      ev_q.push_back({8'h10, e});
      @(posedge clk_i);
      play_req_i <= 1'b0;
   endtask
   // ----------------------------------------------------------------------
   // Output monitor
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (wb_ack_o && !wb_we_i) cmp_rd(wb_dat_o);
      if (arr_accept_o | arr_drop_o | play_take_o | play_fill_o)
         cmp_ev(ev_q.pop_front(), {8'h10, arr_accept_o, arr_drop_o, play_take_o, play_fill_o});
      if (tx_grant_o[0]) cmp_ev(ev_q.pop_front(), {10'h020, tx_class_o[1:0]});
      if (tdm_valid_o) cmp_ev(ev_q.pop_front(), {4'h3, tdm_byte_o});
      if (cyc_n == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(CTRL_OFS, {8'h00, HOLD_RST, FILL_RST, 8'h00});
      wb(1'b1, MASK_OFS, 32'h3);
      wb(1'b1, CTX_SEL_OFS, 32'h5);
      wb(1'b1, CTX_CFG_OFS, 32'h102);
      for (int i = 0; i < 3; i++) arr(2'h0, 7'h05, 2'h0, i < 2 ? 4'h8 : 4'h4);
      rd(CTX_CFG_OFS, 32'h0002_0102);
      rd(STAT_OFS, 32'h2);
      cmp_ev(12'h001, {11'h0, irq_o});
      wb(1'b1, STAT_OFS, 32'h2);
      rd(STAT_OFS, 32'h0);
      cmp_ev(12'h000, {11'h0, irq_o});
      $display("test backplane threshold done");
      repeat (5 * FR) @(posedge clk_i);
      play(4'h2);
      play(4'h2);
      play(4'h1);
      @(posedge clk_i);
      {slot_valid_i, slot_ctx_i, slot_byte_i} <= {1'b1, 7'h05, 8'($random(seed))};
      ev_q.push_back({4'h3, FILL_RST});
      @(posedge clk_i);
      slot_valid_i <= 1'b0;
      rd(STAT_OFS, 32'h1);
      arr(2'h0, 7'h05, 2'h0, 4'h8);
      play(4'h2);
      $display("test underrun done");
      wb(1'b1, CTRL_OFS, 32'h0004_ff01);
      wb(1'b1, CTX_SEL_OFS, 32'h6);
      wb(1'b1, CTX_CFG_OFS, 32'h100);
      for (int i = 0; i < 16; i++) arr(2'h0, 7'h06, 2'h0, i < 15 ? 4'h8 : 4'h4);
      arr(2'h2, 7'h00, 2'h2, 4'h8);
      repeat (3) @(posedge clk_i);
      cmp_ev(12'h004, {8'h00, host_nonempty_o});
      host_pop_i <= 4'h4;
      @(posedge clk_i);
      host_pop_i <= 4'h0;
      repeat (3) @(posedge clk_i);
      cmp_ev(12'h000, {8'h00, host_nonempty_o});
      $display("test network and host done");
      arr(2'h1, 7'h00, 2'h1, 4'h8);
      arr(2'h1, 7'h00, 2'h3, 4'h8);
      arr(2'h1, 7'h00, 2'h0, 4'h8);
      ev_q.push_back(12'h083);
      ev_q.push_back(12'h081);
      ev_q.push_back(12'h080);
      {mac_en, mac_slow} <= 2'b11;
      repeat (100) @(posedge clk_i);
      if (ev_q.size() != 0) n_fail++;
      $display("test port priority done");
      stop_test();
   end
endmodule // queue_manager_tb
bind queue_manager qm_properties #(.NPORT(NPORT)) u_props (.*);
`default_nettype wire
